//--- rtl/uis_event_status.sv
`timescale 1ns/1ns
// Contract
// - tx/rx event bits for endpoints 7..1 at bits 25..12, descending
// - bit 11 control tx event, bit 10 control rx event
// - bit 8 set on setup token; bit 9 reserved
// - bit 7 set on vbus rising edge
// - bit 6 set when dma reason register changes
// - bit 5 set on full-speed to high-speed change
// - bit 5 not set on entering full-speed suspend
// - bit 4 set on suspend to active
// - bit 3 set on active to suspend
// - bit 2 set on each pseudo frame tick
// - pseudo tick free-running: 1 ms full speed, 125 us high speed
// - bit 1 set on each received frame start packet
// - bit 0 set on bus reset
// - with otg set, bit 0 reports 2 ms se0 instead of bus reset
// - read-only 24-bit ident: chip code low byte, then chip code high byte, over 8-bit version
// - frame number bits 10..0, microframe bits 13..11, read-only
// - 8-bit read of frame number gives lower byte first
// - writing one clears an event bit; zero leaves it
// - interrupt out while any enabled event bit is set
module uis_event_status #(
  parameter logic [15:0] CHIP_CODE = uis_pkg::CHIP_CODE_DEFAULT,
  parameter logic [7:0] VERSION = uis_pkg::VERSION_DEFAULT,
  parameter int TICK_FS = uis_pkg::TICK_FS_CYCLES,
  parameter int TICK_HS = uis_pkg::TICK_HS_CYCLES,
  parameter int SE0_LEN = uis_pkg::SE0_OTG_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire uis_pkg::uis_req_type req,
  input wire logic byteMode,
  output logic [31:0] rdata,
  output logic rvalid,
  // internal event sources (same clock)
  input wire uis_pkg::uis_events_type events,
  input wire logic [7:0] dmaReason,
  input wire logic highSpeed,
  input wire logic sofFrameValid,
  input wire logic [10:0] sofFrame,
  input wire logic [2:0] sofMicro,
  // pins from outside the clock domain
  input wire logic vbusPin,
  input wire logic busSuspendPin,
  input wire logic se0Pin,
  // interrupt and status
  output logic intOut,
  output logic busResetOut
);
  // synchronisers: stage one is read only by stage two
  logic [2:0] syncA;
  logic [2:0] syncB;
  always_ff @(posedge clk) begin
    syncA <= {vbusPin, busSuspendPin, se0Pin};
    syncB <= syncA;
  end
  logic vbusQ;
  logic suspendQ;
  logic se0Q;
  logic hsQ;
  logic [7:0] dmaQ;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      vbusQ <= 1'b0;
      suspendQ <= 1'b0;
      se0Q <= 1'b0;
      hsQ <= 1'b0;
      dmaQ <= 8'h00;
    end else begin
      vbusQ <= syncB[2];
      suspendQ <= syncB[1];
      se0Q <= syncB[0];
      hsQ <= highSpeed;
      dmaQ <= dmaReason;
    end
  end

  // bus state machine, tracks active/suspend
  uis_pkg::uis_bus_type busState;
  uis_pkg::uis_bus_type next_busState;
  wire goSuspend = (busState != uis_pkg::BUS_SUSPEND) && syncB[1] && !suspendQ;
  wire goActive = (busState == uis_pkg::BUS_SUSPEND) && !syncB[1];
  always_comb begin
    next_busState = busState;
    case (busState)
      uis_pkg::BUS_IDLE: begin
        if (!syncB[1]) next_busState = uis_pkg::BUS_ACTIVE;
      end
      uis_pkg::BUS_ACTIVE: begin
        if (goSuspend) next_busState = uis_pkg::BUS_SUSPEND;
      end
      uis_pkg::BUS_SUSPEND: begin
        if (goActive) next_busState = uis_pkg::BUS_ACTIVE;
      end
      default: next_busState = uis_pkg::BUS_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_b) busState <= uis_pkg::BUS_IDLE;
    else busState <= next_busState;
  end

  // pseudo frame tick, free-running; restarts only on reset
  logic [31:0] tickCount;
  wire [31:0] tickLimit = highSpeed ? 32'(TICK_HS - 1) : 32'(TICK_FS - 1);
  wire frameTick = (tickCount >= tickLimit);
  always_ff @(posedge clk) begin
    if (!rst_b) tickCount <= 32'h0000_0000;
    else if (frameTick) tickCount <= 32'h0000_0000;
    else tickCount <= tickCount + 32'h0000_0001;
  end

  // cycles since the last tick; only the period check reads it
  logic [31:0] tickGap;
  always_ff @(posedge clk) begin
    if (!rst_b || frameTick) tickGap <= 32'h0000_0000;
    else tickGap <= tickGap + 32'h0000_0001;
  end

  // se0 length counter; saturates so a long se0 reports once
  logic [31:0] se0Count;
  wire se0Long = se0Q && (se0Count == 32'(SE0_LEN - 1));
  always_ff @(posedge clk) begin
    if (!rst_b || !se0Q) se0Count <= 32'h0000_0000;
    else if (se0Count != 32'(SE0_LEN)) se0Count <= se0Count + 32'h0000_0001;
  end

  // otg control and enable registers
  // address match, shared by the write strobes
  function automatic logic addrIs(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction
  logic otgMode;
  logic [31:0] enable;
  wire wrEvent = req.wr && addrIs(req.addr, uis_pkg::EVENT_STATUS_OFFSET);
  wire wrEnable = req.wr && addrIs(req.addr, uis_pkg::EVENT_ENABLE_OFFSET);
  wire wrOtg = req.wr && addrIs(req.addr, uis_pkg::OTG_CONTROL_OFFSET);
  // interrupt must see a new mask in the same edge, else it lags a cycle
  wire [31:0] next_enable = wrEnable ? (req.wdata & uis_pkg::EVENT_MASK) : enable;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      otgMode <= 1'b0;
      enable <= uis_pkg::EVENT_RESET;
    end else begin
      if (wrOtg) otgMode <= req.wdata[0];
      if (wrEnable) enable <= req.wdata & uis_pkg::EVENT_MASK;
    end
  end

  // event set vector
  logic [31:0] setVec;
  wire busResetSeen = busResetOut;
  always_comb begin
    setVec = 32'h0000_0000;
    for (int i = 0; i < 7; i++) begin
      setVec[uis_pkg::EP_EVENT_LSB + 2*i + 1] = events.epTx[i];
      setVec[uis_pkg::EP_EVENT_LSB + 2*i] = events.epRx[i];
    end
    setVec[uis_pkg::CTRL_TX_BIT] = events.ctrlTx;
    setVec[uis_pkg::CTRL_RX_BIT] = events.ctrlRx;
    setVec[uis_pkg::SETUP_BIT] = events.setup;
    setVec[uis_pkg::VBUS_BIT] = syncB[2] && !vbusQ;
    setVec[uis_pkg::DMA_BIT] = (dmaReason != dmaQ) || events.dmaChange;
    // only a rising speed; suspend leaves highSpeed unchanged or low
    setVec[uis_pkg::SPEED_BIT] = highSpeed && !hsQ && !goSuspend;
    setVec[uis_pkg::RESUME_BIT] = goActive;
    setVec[uis_pkg::SUSPEND_BIT] = goSuspend;
    setVec[uis_pkg::TICK_BIT] = frameTick;
    setVec[uis_pkg::SOF_BIT] = events.sofRx;
    setVec[uis_pkg::BUS_RESET_BIT] = otgMode ? se0Long : (se0Long && !busResetSeen);
  end

  // sticky status: clear by one, set wins
  logic [31:0] status;
  wire [31:0] clrVec = wrEvent ? req.wdata : 32'h0000_0000;
  wire [31:0] next_status = ((status & ~clrVec) | setVec) & uis_pkg::EVENT_MASK;
  always_ff @(posedge clk) begin
    if (!rst_b) status <= uis_pkg::EVENT_RESET;
    else status <= next_status;
  end

  // bus reset level output, held while se0 is long and not in otg mode
  always_ff @(posedge clk) begin
    if (!rst_b) busResetOut <= 1'b0;
    else if (!se0Q) busResetOut <= 1'b0;
    else if (se0Long && !otgMode) busResetOut <= 1'b1;
  end

  // interrupt registered from the next masked status
  always_ff @(posedge clk) begin
    if (!rst_b) intOut <= 1'b0;
    else intOut <= |(next_status & next_enable);
  end

  // frame number latch on each good sof
  logic [15:0] frame;
  always_ff @(posedge clk) begin
    if (!rst_b) frame <= uis_pkg::FRAME_RESET;
    else if (sofFrameValid) frame <= {2'b00, sofMicro, sofFrame};
  end

  // read decode; byte mode returns low byte of frame first
  logic frameHalf;
  wire rdFrame = req.rd && (req.addr == uis_pkg::FRAME_NUMBER_OFFSET);
  wire [23:0] identWord = {CHIP_CODE[7:0], CHIP_CODE[15:8], VERSION};
  logic [31:0] readMux;
  always_comb begin
    if (req.addr == uis_pkg::EVENT_STATUS_OFFSET) readMux = status;
    else if (req.addr == uis_pkg::EVENT_ENABLE_OFFSET) readMux = enable;
    else if (req.addr == uis_pkg::OTG_CONTROL_OFFSET) readMux = {31'h0, otgMode};
    else if (req.addr == uis_pkg::CHIP_IDENT_OFFSET) readMux = {8'h00, identWord};
    else if (req.addr == uis_pkg::FRAME_NUMBER_OFFSET) begin
      if (byteMode) readMux = {24'h0, frameHalf ? frame[15:8] : frame[7:0]};
      else readMux = {16'h0000, frame};
    end else readMux = 32'h0000_0000;
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata <= 32'h0000_0000;
      rvalid <= 1'b0;
      frameHalf <= 1'b0;
    end else begin
      rvalid <= req.rd;
      if (req.rd) rdata <= readMux;
      if (rdFrame && byteMode) frameHalf <= !frameHalf;
      else if (req.rd) frameHalf <= 1'b0;
    end
  end

  // checks
  AST_SET_WINS: assert property (@(posedge clk) disable iff (!rst_b)
    (rst_b && setVec[1]) |=> status[1]) else $error("sof event lost");
  AST_W1C: assert property (@(posedge clk) disable iff (!rst_b)
    (wrEvent && req.wdata[7] && !setVec[7]) |=> !status[7]) else $error("clear failed");
  AST_RESV: assert property (@(posedge clk) disable iff (!rst_b)
    (status[31:26] == 6'h00) && !status[9]) else $error("reserved bit set");
  AST_INT: assert property (@(posedge clk) disable iff (!rst_b)
    (|(status & enable)) |-> intOut) else $error("int missing");
  AST_INT_LOW: assert property (@(posedge clk) disable iff (!rst_b)
    !(|(status & enable)) |-> !intOut) else $error("int without source");
  AST_OTG: assert property (@(posedge clk) disable iff (!rst_b)
    otgMode |-> !busResetOut) else $error("bus reset in otg mode");
  AST_TICK: assert property (@(posedge clk) disable iff (!rst_b)
    frameTick |=> status[2]) else $error("pseudo tick lost");
  AST_EP7: assert property (@(posedge clk) disable iff (!rst_b)
    events.epTx[6] |=> status[25]) else $error("ep7 tx lost");
  AST_SUSPEND: assert property (@(posedge clk) disable iff (!rst_b)
    goSuspend |=> status[3] && busState == uis_pkg::BUS_SUSPEND) else $error("suspend");
  AST_FRAME: assert property (@(posedge clk) disable iff (!rst_b)
    sofFrameValid |=> frame[10:0] == $past(sofFrame)) else $error("frame not latched");

  // endpoint bits, one per buffer, fixed positions
  AST_EP1_RX: assert property (@(posedge clk) disable iff (!rst_b)
    events.epRx[0] |=> status[12]) else $error("ep1 rx lost");
  AST_EP1_TX: assert property (@(posedge clk) disable iff (!rst_b)
    events.epTx[0] |=> status[13]) else $error("ep1 tx lost");
  AST_EP2_RX: assert property (@(posedge clk) disable iff (!rst_b)
    events.epRx[1] |=> status[14]) else $error("ep2 rx lost");
  AST_EP2_TX: assert property (@(posedge clk) disable iff (!rst_b)
    events.epTx[1] |=> status[15]) else $error("ep2 tx lost");
  AST_EP3_RX: assert property (@(posedge clk) disable iff (!rst_b)
    events.epRx[2] |=> status[16]) else $error("ep3 rx lost");
  AST_EP3_TX: assert property (@(posedge clk) disable iff (!rst_b)
    events.epTx[2] |=> status[17]) else $error("ep3 tx lost");
  AST_EP4_RX: assert property (@(posedge clk) disable iff (!rst_b)
    events.epRx[3] |=> status[18]) else $error("ep4 rx lost");
  AST_EP4_TX: assert property (@(posedge clk) disable iff (!rst_b)
    events.epTx[3] |=> status[19]) else $error("ep4 tx lost");
  AST_EP5_RX: assert property (@(posedge clk) disable iff (!rst_b)
    events.epRx[4] |=> status[20]) else $error("ep5 rx lost");
  AST_EP5_TX: assert property (@(posedge clk) disable iff (!rst_b)
    events.epTx[4] |=> status[21]) else $error("ep5 tx lost");
  AST_EP6_RX: assert property (@(posedge clk) disable iff (!rst_b)
    events.epRx[5] |=> status[22]) else $error("ep6 rx lost");
  AST_EP6_TX: assert property (@(posedge clk) disable iff (!rst_b)
    events.epTx[5] |=> status[23]) else $error("ep6 tx lost");
  AST_EP7_RX: assert property (@(posedge clk) disable iff (!rst_b)
    events.epRx[6] |=> status[24]) else $error("ep7 rx lost");

  // control endpoint events
  AST_CTRL_TX: assert property (@(posedge clk) disable iff (!rst_b)
    events.ctrlTx |=> status[11]) else $error("control tx lost");
  AST_CTRL_RX: assert property (@(posedge clk) disable iff (!rst_b)
    events.ctrlRx |=> status[10]) else $error("control rx lost");
  AST_SETUP: assert property (@(posedge clk) disable iff (!rst_b)
    events.setup |=> status[8]) else $error("setup lost");

  // level changes seen on pins and side inputs
  AST_VBUS: assert property (@(posedge clk) disable iff (!rst_b)
    (syncB[2] && !vbusQ) |=> status[7]) else $error("vbus rise lost");
  AST_DMA: assert property (@(posedge clk) disable iff (!rst_b)
    (dmaReason != dmaQ) |=> status[6]) else $error("dma change lost");
  AST_SPEED: assert property (@(posedge clk) disable iff (!rst_b)
    ($rose(highSpeed) && !goSuspend) |=> status[5]) else $error("speed change lost");
  AST_NO_SPEED: assert property (@(posedge clk) disable iff (!rst_b)
    (goSuspend && !status[5]) |=> !status[5]) else $error("speed set on suspend");
  AST_RESUME: assert property (@(posedge clk) disable iff (!rst_b)
    goActive |=> status[4] && busState == uis_pkg::BUS_ACTIVE) else $error("resume");

  // tick spacing; a mode switch may shorten one gap but never stretch it
  AST_TICK_GAP: assert property (@(posedge clk) disable iff (!rst_b)
    tickGap < 32'(TICK_FS)) else $error("pseudo tick late");
  AST_TICK_SPACED: assert property (@(posedge clk) disable iff (!rst_b)
    frameTick |=> !frameTick) else $error("pseudo tick doubled");

  // long se0 handling in both modes
  AST_BUS_RESET: assert property (@(posedge clk) disable iff (!rst_b)
    (se0Long && !otgMode && !busResetOut) |=> status[0] && busResetOut) else $error("reset");
  AST_OTG_REPORT: assert property (@(posedge clk) disable iff (!rst_b)
    (se0Long && otgMode) |=> status[0]) else $error("se0 report lost");

  // read side
  AST_IDENT: assert property (@(posedge clk) disable iff (!rst_b)
    (req.rd && req.addr == uis_pkg::CHIP_IDENT_OFFSET) |=>
    rdata == {8'h00, CHIP_CODE[7:0], CHIP_CODE[15:8], VERSION}) else $error("ident");
  AST_FRAME_MICRO: assert property (@(posedge clk) disable iff (!rst_b)
    sofFrameValid |=> frame[13:11] == $past(sofMicro)) else $error("microframe");
  AST_RESV_FRAME: assert property (@(posedge clk) disable iff (!rst_b)
    frame[15:14] == 2'b00) else $error("frame reserved bits set");
  AST_FRAME_BYTE: assert property (@(posedge clk) disable iff (!rst_b)
    (rdFrame && byteMode && !frameHalf) |=>
    rdata == {24'h0, $past(frame[7:0])}) else $error("frame low byte");
  AST_HALF_TOGGLE: assert property (@(posedge clk) disable iff (!rst_b)
    (rdFrame && byteMode) |=> frameHalf != $past(frameHalf)) else $error("byte order");
  AST_RVALID: assert property (@(posedge clk) disable iff (!rst_b)
    req.rd |=> rvalid) else $error("read answer missing");
  AST_RVALID_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
    !req.rd |=> !rvalid) else $error("read answer without read");

  // write one to clear, zero keeps
  AST_W1C_SETUP: assert property (@(posedge clk) disable iff (!rst_b)
    (wrEvent && req.wdata[8] && !events.setup) |=> !status[8]) else $error("setup clear");
  AST_ZERO_KEEPS: assert property (@(posedge clk) disable iff (!rst_b)
    (wrEvent && !req.wdata[8] && status[8]) |=> status[8]) else $error("zero cleared");

  COV_RESUME: cover property (@(posedge clk) disable iff (!rst_b) goActive);
  COV_CLEAR: cover property (@(posedge clk) disable iff (!rst_b) wrEvent ##1 intOut);
  COV_OTG: cover property (@(posedge clk) disable iff (!rst_b) otgMode && se0Long);
  COV_TICK_HS: cover property (@(posedge clk) disable iff (!rst_b) frameTick && highSpeed);
  COV_BUS_RESET: cover property (@(posedge clk) disable iff (!rst_b) busResetOut);
endmodule

//--- rtl/uis_pkg.sv
package uis_pkg;
  // register offsets (byte addresses on the parallel register port)
  localparam logic [7:0] EVENT_STATUS_OFFSET = 8'h18;
  localparam logic [7:0] CHIP_IDENT_OFFSET = 8'h70;
  localparam logic [7:0] FRAME_NUMBER_OFFSET = 8'h74;
  localparam logic [7:0] EVENT_ENABLE_OFFSET = 8'h14;
  localparam logic [7:0] OTG_CONTROL_OFFSET = 8'h12;
  // event bit positions
  localparam int EP_EVENT_LSB = 12;
  localparam int EP_EVENT_MSB = 25;
  localparam int CTRL_TX_BIT = 11;
  localparam int CTRL_RX_BIT = 10;
  localparam int RESERVED_BIT = 9;
  localparam int SETUP_BIT = 8;
  localparam int VBUS_BIT = 7;
  localparam int DMA_BIT = 6;
  localparam int SPEED_BIT = 5;
  localparam int RESUME_BIT = 4;
  localparam int SUSPEND_BIT = 3;
  localparam int TICK_BIT = 2;
  localparam int SOF_BIT = 1;
  localparam int BUS_RESET_BIT = 0;
  // writable/settable event bits: 25..10, 8..0
  localparam logic [31:0] EVENT_MASK = 32'h03ff_fdff;
  localparam logic [31:0] EVENT_RESET = 32'h0000_0000;
  localparam logic [31:0] EVENT_BUS_RESET = 32'h0000_0001;
  localparam logic [15:0] FRAME_RESET = 16'h0000;
  // arbitrary identity values, not of any real part
  localparam logic [15:0] CHIP_CODE_DEFAULT = 16'h5a3c;
  localparam logic [7:0] VERSION_DEFAULT = 8'h01;
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_FS_NS = 1000000;
  localparam int TICK_HS_NS = 125000;
  localparam int SE0_OTG_NS = 2000000;
  localparam int TICK_FS_CYCLES = TICK_FS_NS / CLK_PERIOD_NS;
  localparam int TICK_HS_CYCLES = TICK_HS_NS / CLK_PERIOD_NS;
  localparam int SE0_OTG_CYCLES = (SE0_OTG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // hardware event sources
  typedef struct packed {
    logic [6:0] epTx;
    logic [6:0] epRx;
    logic ctrlTx;
    logic ctrlRx;
    logic setup;
    logic dmaChange;
    logic sofRx;
  } uis_events_type;

  // register port request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } uis_req_type;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_ACTIVE = 3'b010,
    BUS_SUSPEND = 3'b100
  } uis_bus_type;
endpackage

//--- sim/tb_uis_event_status.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb_uis_event_status;
  localparam int FS = 40;
  localparam int HS = 16;
  localparam int SE = 8;
  localparam logic [7:0] ST = 8'h18;
  localparam logic [7:0] EN = 8'h14;
  localparam logic [7:0] OT = 8'h12;
  localparam logic [7:0] ID = 8'h70;
  localparam logic [7:0] FN = 8'h74;
  localparam logic [31:0] NT = 32'hffff_fffb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  uis_pkg::uis_req_type req;
  uis_pkg::uis_events_type events = '0;
  logic byteMode, rvalid, intOut, busResetOut;
  logic highSpeed = 1'b0;
  logic sofFrameValid = 1'b0;
  logic vbusPin = 1'b0;
  logic busSuspendPin = 1'b0;
  logic se0Pin = 1'b0;
  logic [7:0] dmaReason = 8'h00;
  logic [10:0] sofFrame = '0;
  logic [2:0] sofMicro = '0;
  logic [31:0] rdata, e, qe, qm;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  int seed = 33625;

  always #50 clk = ~clk;

  uis_cpu_model cpu_u (.clk(clk), .req(req), .byteMode(byteMode));
  uis_event_status #(.TICK_FS(FS), .TICK_HS(HS), .SE0_LEN(SE)) dut_u (
    .clk(clk), .rst_b(rst_b), .req(req), .byteMode(byteMode), .rdata(rdata),
    .rvalid(rvalid), .events(events), .dmaReason(dmaReason), .highSpeed(highSpeed),
    .sofFrameValid(sofFrameValid), .sofFrame(sofFrame), .sofMicro(sofMicro),
    .vbusPin(vbusPin), .busSuspendPin(busSuspendPin), .se0Pin(se0Pin),
    .intOut(intOut), .busResetOut(busResetOut));

  // each answer is held against the oldest note
  always @(negedge clk) begin
    if (rvalid === 1'b1) begin
      qe = cpu_u.expQ.pop_front();
      qm = cpu_u.mskQ.pop_front();
      `CHK("rdata", qe, rdata & qm)
    end
  end

  // hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      failures++;
      test_done();
    end
  end

  task test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic waitc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic pulse(input uis_pkg::uis_events_type v);
    @(negedge clk);
    events = v;
    @(negedge clk);
    events = '0;
  endtask

  // pins pass two sync stages, so allow a few cycles before looking
  task automatic seen(input logic [31:0] b);
    waitc(5);
    cpu_u.rd(ST, b, NT);
    cpu_u.wr(ST, b);
  endtask

  // status bit of each event source, struct lsb first
  function automatic int evBit(input int k);
    if (k >= 12) return 13 + 2 * (k - 12);
    if (k >= 5) return 12 + 2 * (k - 5);
    case (k)
      4: return 11;
      3: return 10;
      2: return 8;
      1: return 6;
      default: return 1;
    endcase
  endfunction

  // main sequence; the free-running tick bit is masked outside its own test
  initial begin
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    waitc(3);
    e = {uis_pkg::CHIP_CODE_DEFAULT[7:0], uis_pkg::CHIP_CODE_DEFAULT[15:8], 8'h01};
    cpu_u.rd(ID, e, '1);
    cpu_u.wr(ID, 32'h0);
    cpu_u.rd(ID, e, '1);
    cpu_u.rd(FN, 32'h0, '1);
    cpu_u.rd(8'h40, 32'h0, '1);
    for (int k = 0; k < 19; k++) begin
      pulse(uis_pkg::uis_events_type'(19'h1 << k));
      cpu_u.rd(ST, 32'h1 << evBit(k), NT);
      cpu_u.wr(ST, 32'h1 << evBit(k));
      cpu_u.rd(ST, 32'h0, NT);
    end
    fork
      cpu_u.wr(ST, 32'h2000);
      pulse(uis_pkg::uis_events_type'(19'h1000));
    join
    cpu_u.rd(ST, 32'h2000, NT);
    cpu_u.wr(EN, 32'h2000);
    waitc(3);
    `CHK("intOut", 1'b1, intOut)
    cpu_u.wr(ST, 32'h2000);
    waitc(3);
    `CHK("intOut", 1'b0, intOut)
    vbusPin = 1'b1;
    seen(32'h80);
    dmaReason = 8'h04;
    seen(32'h40);
    dmaReason = 8'h00;
    seen(32'h40);
    highSpeed = 1'b1;
    seen(32'h20);
    highSpeed = 1'b0;
    busSuspendPin = 1'b1;
    seen(32'h08);
    busSuspendPin = 1'b0;
    seen(32'h10);
    cpu_u.wr(EN, 32'h4);
    for (int h = 0; h < 2; h++) begin
      highSpeed = h[0];
      cpu_u.wr(ST, 32'h4);
      waitc(2);
      for (int n = 0; n < 100 && intOut !== 1'b1; n++) @(negedge clk);
      cpu_u.wr(ST, 32'h4);
      waitc((h == 1 ? HS : FS) - 10);
      cpu_u.rd(ST, 32'h0, 32'h4);
      waitc(10);
      cpu_u.rd(ST, 32'h4, 32'h4);
    end
    cpu_u.wr(EN, 32'h0);
    highSpeed = 1'b0;
    // the high-speed pass above raised the speed bit; drop it first
    cpu_u.wr(ST, 32'h20);
    se0Pin = 1'b1;
    waitc(SE / 2);
    se0Pin = 1'b0;
    seen(32'h0);
    se0Pin = 1'b1;
    waitc(SE + 6);
    `CHK("busResetOut", 1'b1, busResetOut)
    se0Pin = 1'b0;
    waitc(5);
    cpu_u.rd(ST, 32'h1, 32'h1);
    cpu_u.wr(ST, 32'h1);
    cpu_u.wr(OT, 32'h1);
    se0Pin = 1'b1;
    waitc(SE + 6);
    `CHK("busResetOut", 1'b0, busResetOut)
    se0Pin = 1'b0;
    seen(32'h1);
    {sofMicro, sofFrame} = 14'($random(seed));
    sofFrameValid = 1'b1;
    @(negedge clk);
    sofFrameValid = 1'b0;
    e = {18'h0, sofMicro, sofFrame};
    cpu_u.wr(FN, 32'h0);
    cpu_u.rd(FN, e, '1);
    cpu_u.byteMode = 1'b1;
    cpu_u.rd(FN, {24'h0, e[7:0]}, '1);
    cpu_u.rd(FN, {24'h0, e[15:8]}, '1);
    waitc(3);
    test_done();
  end
endmodule

//--- sim/uis_cpu_model.sv
`timescale 1ns/1ns
// host processor on the register port, driving just after falling edges
module uis_cpu_model (
  // clock
  input wire logic clk,
  // register port
  output uis_pkg::uis_req_type req,
  output logic byteMode
);
  logic [31:0] expQ[$];
  logic [31:0] mskQ[$];

  // idle port at time zero
  initial begin
    req = '0;
    byteMode = 1'b0;
  end

  // one-cycle strobe; idle lines go inverted so a stale address is never trusted
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    req <= {~w, w, a, d};
    @(negedge clk);
    req <= {2'b00, ~a, ~d};
  endtask

  // clearing writes carry ones only in the bits to clear
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask

  // the expected answer is noted before the strobe leaves
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    expQ.push_back(e);
    mskQ.push_back(m);
    acc(1'b0, a, '0);
  endtask
endmodule
